// ---- include/frame_sync_if.sv ----
// frame_sync_if: per-frame strobe handed from the frame edge detector to the register bank
// assumes a single clock domain
`timescale 1ns/100ps
interface frame_sync_if;
  logic frame_tick;
  logic trig_edge;
  modport src (output frame_tick, output trig_edge);
  modport dst (input frame_tick, input trig_edge);
endinterface : frame_sync_if

// ---- include/param_save_cfg.svh ----
// param_save_cfg.svh: offsets, field positions, reset values and counts of the control registers
// assumes word addressing on the control port; offsets are register indices
`ifndef PARAM_SAVE_CFG_SVH
`define PARAM_SAVE_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define ADDR_PARAM_SAVE_0 16'h0800
`define ADDR_PARAM_SAVE_7 16'h0807
`define ADDR_PIN_LEVEL 16'h0808
`define ADDR_CORE_CONTROL 16'h081c
`define ADDR_SPARE_A 16'h081d
`define ADDR_SERIAL_OUT 16'h081e
`define ADDR_SERIAL_IN 16'h081f
`define ADDR_PIN_CONFIG_LOW 16'h0820
`define ADDR_PIN_CONFIG_HIGH 16'h0821
`define ADDR_AUX_POWER 16'h0822
`define ADDR_SPARE_B 16'h0823
`define ADDR_AUX_ENABLE 16'h0824
`define ADDR_SPARE_C 16'h0825
`define ADDR_OSC_POWER_DOWN 16'h0826
`define ADDR_OUT_CONV_SETUP 16'h0827

// ****************************************
// field positions
// ****************************************
`define BIT_AUX_DATA_HOST_WRITE 8
`define BIT_PIN_LEVEL_HOST_WRITE 7
`define BIT_PARAM_SAVE_HOST_WRITE 6

// ****************************************
// widths and reset values
// ****************************************
`define PARAM_WIDTH 28
`define PIN_COUNT 12
`define PARAM_SAVE_COUNT 8
`define RST_PARAM_SAVE 32'h0000_0000
`define RST_PIN_LEVEL 16'h0000
`define RST_CORE_CONTROL 16'h0000
`define RST_PIN_CONFIG 24'h00_0000
`define RST_WORD 32'h0000_0000

`endif

// ---- include/param_save_pkg.sv ----
// param_save_pkg: types shared by the control register bank
// assumes param_save_cfg.svh is on the include path
package param_save_pkg;
  typedef logic [31:0] reg_word_t;
  typedef logic [15:0] reg_addr_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAVE = 3'b010,
    ST_RESTORE = 3'b100
  } eeprom_state_e;
endpackage : param_save_pkg

// ---- rtl/frame_edge_detect.sv ----
// frame_edge_detect: synchronises the frame clock and the save trigger pin and makes pulses
// assumes both inputs are asynchronous pins
`timescale 1ns/100ps
module frame_edge_detect (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_frame_clk,
  input wire logic i_save_trigger,
  input wire logic i_trigger_falling,
  frame_sync_if.src sync
);
  logic [2:0] frame_sr;
  logic [2:0] trig_sr;
  logic [2:0] next_frame_sr;
  logic [2:0] next_trig_sr;

  always_comb begin
    next_frame_sr = {frame_sr[1:0], i_frame_clk};
    next_trig_sr = {trig_sr[1:0], i_save_trigger};
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      frame_sr <= 3'h0;
      trig_sr <= 3'h0;
    end else begin
      frame_sr <= next_frame_sr;
      trig_sr <= next_trig_sr;
    end
  end

  // ****************************************
  // edge pulses, read only from stages 1 and 2
  // ****************************************
  assign sync.frame_tick = frame_sr[1] & ~frame_sr[2];
  // polarity selectable
  assign sync.trig_edge = i_trigger_falling ? (~trig_sr[1] & trig_sr[2])
                                            : (trig_sr[1] & ~trig_sr[2]);
endmodule : frame_edge_detect

// ---- rtl/param_eeprom_seq.sv ----
// param_eeprom_seq: walks the parameter-save words out to, or back from, the external store
// assumes a word-wide store port with one-cycle request and done answer
`timescale 1ns/100ps
module param_eeprom_seq
  import param_save_pkg::*;
#(
  parameter int COUNT = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start_save,
  input wire logic i_start_restore,
  input wire logic i_store_done,
  output logic o_store_req,
  output logic o_store_write,
  output logic [$clog2(COUNT)-1:0] o_index,
  output logic o_busy,
  output logic o_restore_load
);
  initial begin
    if (COUNT < 2) $error("param_eeprom_seq: COUNT must be at least 2");
  end

  eeprom_state_e state;
  eeprom_state_e next_state;
  logic [$clog2(COUNT)-1:0] next_index;
  logic next_req;
  logic req;

  always_comb begin
    next_state = state;
    next_index = o_index;
    next_req = 1'b0;
    case (state)
      ST_IDLE: begin
        if (i_start_restore) begin
          next_state = ST_RESTORE;
          next_index = '0;
          next_req = 1'b1;
        end else if (i_start_save) begin
          next_state = ST_SAVE;
          next_index = '0;
          next_req = 1'b1;
        end
      end
      ST_SAVE, ST_RESTORE: begin
        if (i_store_done) begin
          if (o_index == $clog2(COUNT)'(COUNT - 1)) begin
            next_state = ST_IDLE;
          end else begin
            next_index = o_index + 1'b1;
            next_req = 1'b1;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      o_index <= '0;
      req <= 1'b0;
    end else begin
      state <= next_state;
      o_index <= next_index;
      req <= next_req;
    end
  end

  assign o_store_req = req;
  assign o_store_write = (state == ST_SAVE);
  assign o_busy = (state != ST_IDLE);
  assign o_restore_load = (state == ST_RESTORE) & i_store_done;
endmodule : param_eeprom_seq

// ---- rtl/param_save_regs.sv ----
// param_save_regs: parameter-save registers, pin-level register and control register map
// assumes a word-addressed control port (spi or i2c front end already decoded) on i_clk
`timescale 1ns/100ps
`include "param_save_cfg.svh"
module param_save_regs (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_frame_clk,
  input wire logic i_save_trigger,
  input wire logic i_trigger_falling,
  input wire logic i_self_boot,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire param_save_pkg::reg_addr_t i_reg_addr,
  input wire param_save_pkg::reg_word_t i_reg_wdata,
  output param_save_pkg::reg_word_t o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic [`PARAM_SAVE_COUNT*`PARAM_WIDTH-1:0] i_core_params,
  input wire logic [`PIN_COUNT-1:0] i_core_pin_level,
  input wire logic [`PIN_COUNT-1:0] i_pin_in,
  output logic [`PIN_COUNT-1:0] o_pin_out,
  output logic [`PIN_COUNT*4-1:0] o_pin_config,
  output logic o_aux_data_host_write_mode,
  output logic o_store_req,
  output logic o_store_write,
  output logic [2:0] o_store_index,
  output logic [`PARAM_WIDTH-1:0] o_store_wdata,
  input wire logic [`PARAM_WIDTH-1:0] i_store_rdata,
  input wire logic i_store_done,
  output logic o_store_busy
);
  import param_save_pkg::*;

  localparam int NSAVE = `PARAM_SAVE_COUNT;
  localparam int PW = `PARAM_WIDTH;
  localparam int NPIN = `PIN_COUNT;

  // ****************************************
  // state
  // ****************************************
  logic [PW-1:0] param_save [NSAVE];
  logic [PW-1:0] next_param_save [NSAVE];
  logic [NPIN-1:0] pin_level_setting;
  logic [NPIN-1:0] next_pin_level_setting;
  logic [NPIN-1:0] pin_out;
  logic [NPIN-1:0] next_pin_out;
  logic [NPIN-1:0] pin_host_pending;
  logic [NPIN-1:0] next_pin_host_pending;
  logic [15:0] core_control;
  logic [15:0] next_core_control;
  logic [15:0] serial_output_control;
  logic [15:0] next_serial_output_control;
  logic [7:0] serial_input_control;
  logic [7:0] next_serial_input_control;
  logic [23:0] pin_config_low;
  logic [23:0] next_pin_config_low;
  logic [23:0] pin_config_high;
  logic [23:0] next_pin_config_high;
  logic [15:0] aux_converter_power_control;
  logic [15:0] next_aux_converter_power_control;
  logic [15:0] aux_converter_enable;
  logic [15:0] next_aux_converter_enable;
  logic [15:0] oscillator_power_down;
  logic [15:0] next_oscillator_power_down;
  logic [15:0] output_converter_setup;
  logic [15:0] next_output_converter_setup;
  reg_word_t rdata;
  reg_word_t next_rdata;
  logic rvalid;
  logic boot_pending;
  logic next_boot_pending;
  logic [NPIN-1:0] pin_sync1;
  logic [NPIN-1:0] pin_sync2;

  logic param_save_host_write_mode;
  logic pin_level_host_write_mode;
  logic seq_busy;
  logic restore_load;
  logic start_restore;
  logic [2:0] seq_index;

  assign param_save_host_write_mode = core_control[`BIT_PARAM_SAVE_HOST_WRITE];
  assign pin_level_host_write_mode = core_control[`BIT_PIN_LEVEL_HOST_WRITE];

  frame_sync_if sync ();

  frame_edge_detect u_edge (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_frame_clk(i_frame_clk),
    .i_save_trigger(i_save_trigger),
    .i_trigger_falling(i_trigger_falling),
    .sync(sync.src)
  );

  param_eeprom_seq #(.COUNT(NSAVE)) u_seq (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start_save(sync.trig_edge & ~start_restore),
    .i_start_restore(start_restore),
    .i_store_done(i_store_done),
    .o_store_req(o_store_req),
    .o_store_write(o_store_write),
    .o_index(seq_index),
    .o_busy(seq_busy),
    .o_restore_load(restore_load)
  );

  // restore is launched once, the first cycle after reset release, when self-boot is strapped
  assign start_restore = boot_pending & i_self_boot;

  // ****************************************
  // register writes and core updates
  // ****************************************
  always_comb begin
    for (int i = 0; i < NSAVE; i++) begin
      next_param_save[i] = param_save[i];
    end
    next_core_control = core_control;
    next_serial_output_control = serial_output_control;
    next_serial_input_control = serial_input_control;
    next_pin_config_low = pin_config_low;
    next_pin_config_high = pin_config_high;
    next_aux_converter_power_control = aux_converter_power_control;
    next_aux_converter_enable = aux_converter_enable;
    next_oscillator_power_down = oscillator_power_down;
    next_output_converter_setup = output_converter_setup;
    next_pin_level_setting = pin_level_setting;
    next_pin_host_pending = pin_host_pending;
    next_pin_out = pin_out;
    next_boot_pending = 1'b0;

    // core refresh once per sample period; frozen while saving so the eeprom image is coherent
    if (sync.frame_tick && !param_save_host_write_mode && !seq_busy) begin
      for (int i = 0; i < NSAVE; i++) begin
        next_param_save[i] = i_core_params[i*PW +: PW];
      end
    end

    if (i_reg_wr) begin
      if (i_reg_addr >= `ADDR_PARAM_SAVE_0 && i_reg_addr <= `ADDR_PARAM_SAVE_7) begin
        if (param_save_host_write_mode) begin
          next_param_save[i_reg_addr[2:0]] = i_reg_wdata[PW-1:0];
        end
      end
      case (i_reg_addr)
        `ADDR_PIN_LEVEL: begin
          if (pin_level_host_write_mode) begin
            next_pin_level_setting = i_reg_wdata[NPIN-1:0];
            next_pin_host_pending = i_reg_wdata[NPIN-1:0];
          end
        end
        `ADDR_CORE_CONTROL: next_core_control = i_reg_wdata[15:0];
        `ADDR_SERIAL_OUT: next_serial_output_control = i_reg_wdata[15:0];
        `ADDR_SERIAL_IN: next_serial_input_control = i_reg_wdata[7:0];
        `ADDR_PIN_CONFIG_LOW: next_pin_config_low = i_reg_wdata[23:0];
        `ADDR_PIN_CONFIG_HIGH: next_pin_config_high = i_reg_wdata[23:0];
        `ADDR_AUX_POWER: next_aux_converter_power_control = i_reg_wdata[15:0];
        `ADDR_AUX_ENABLE: next_aux_converter_enable = i_reg_wdata[15:0];
        `ADDR_OSC_POWER_DOWN: next_oscillator_power_down = i_reg_wdata[15:0];
        `ADDR_OUT_CONV_SETUP: next_output_converter_setup = i_reg_wdata[15:0];
        default: begin
        end
      endcase
    end

    // restored words win over both host and core in the cycle they arrive
    if (restore_load) begin
      next_param_save[seq_index] = i_store_rdata;
    end

    // pins exchange with the register only on the frame tick
    if (sync.frame_tick) begin
      if (pin_level_host_write_mode) begin
        next_pin_out = pin_host_pending;
      end else begin
        next_pin_out = i_core_pin_level;
        next_pin_level_setting = pin_sync2;
        next_pin_host_pending = i_core_pin_level;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NSAVE; i++) begin
        param_save[i] <= PW'(`RST_PARAM_SAVE);
      end
      core_control <= `RST_CORE_CONTROL;
      serial_output_control <= 16'h0000;
      serial_input_control <= 8'h00;
      pin_config_low <= `RST_PIN_CONFIG;
      pin_config_high <= `RST_PIN_CONFIG;
      aux_converter_power_control <= 16'h0000;
      aux_converter_enable <= 16'h0000;
      oscillator_power_down <= 16'h0000;
      output_converter_setup <= 16'h0000;
      pin_level_setting <= NPIN'(`RST_PIN_LEVEL);
      pin_host_pending <= NPIN'(`RST_PIN_LEVEL);
      pin_out <= NPIN'(`RST_PIN_LEVEL);
      boot_pending <= 1'b1;
    end else begin
      for (int i = 0; i < NSAVE; i++) begin
        param_save[i] <= next_param_save[i];
      end
      core_control <= next_core_control;
      serial_output_control <= next_serial_output_control;
      serial_input_control <= next_serial_input_control;
      pin_config_low <= next_pin_config_low;
      pin_config_high <= next_pin_config_high;
      aux_converter_power_control <= next_aux_converter_power_control;
      aux_converter_enable <= next_aux_converter_enable;
      oscillator_power_down <= next_oscillator_power_down;
      output_converter_setup <= next_output_converter_setup;
      pin_level_setting <= next_pin_level_setting;
      pin_host_pending <= next_pin_host_pending;
      pin_out <= next_pin_out;
      boot_pending <= next_boot_pending;
    end
  end

  // ****************************************
  // pin input synchroniser
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_sync1 <= '0;
      pin_sync2 <= '0;
    end else begin
      pin_sync1 <= i_pin_in;
      pin_sync2 <= pin_sync1;
    end
  end

  // ****************************************
  // read path, one cycle after the read strobe
  // ****************************************
  always_comb begin
    next_rdata = `RST_WORD;
    if (i_reg_addr >= `ADDR_PARAM_SAVE_0 && i_reg_addr <= `ADDR_PARAM_SAVE_7) begin
      next_rdata = {4'h0, param_save[i_reg_addr[2:0]]};
    end
    case (i_reg_addr)
      `ADDR_PIN_LEVEL: next_rdata = {20'h00000, pin_level_setting};
      `ADDR_CORE_CONTROL: next_rdata = {16'h0000, core_control};
      `ADDR_SERIAL_OUT: next_rdata = {16'h0000, serial_output_control};
      `ADDR_SERIAL_IN: next_rdata = {24'h000000, serial_input_control};
      `ADDR_PIN_CONFIG_LOW: next_rdata = {8'h00, pin_config_low};
      `ADDR_PIN_CONFIG_HIGH: next_rdata = {8'h00, pin_config_high};
      `ADDR_AUX_POWER: next_rdata = {16'h0000, aux_converter_power_control};
      `ADDR_AUX_ENABLE: next_rdata = {16'h0000, aux_converter_enable};
      `ADDR_OSC_POWER_DOWN: next_rdata = {16'h0000, oscillator_power_down};
      `ADDR_OUT_CONV_SETUP: next_rdata = {16'h0000, output_converter_setup};
      default: begin
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata <= `RST_WORD;
      rvalid <= 1'b0;
    end else begin
      rdata <= i_reg_rd ? next_rdata : rdata;
      rvalid <= i_reg_rd;
    end
  end

  assign o_reg_rdata = rdata;
  assign o_reg_rvalid = rvalid;
  assign o_pin_out = pin_out;
  assign o_pin_config = {pin_config_high, pin_config_low};
  assign o_aux_data_host_write_mode = core_control[`BIT_AUX_DATA_HOST_WRITE];
  assign o_store_index = seq_index;
  assign o_store_wdata = param_save[seq_index];
  assign o_store_busy = seq_busy;
endmodule : param_save_regs

// ---- test/eeprom_model.sv ----
// eeprom_model: behavioural external parameter store on the word-wide store port
// assumes one request at a time; i_slow stretches every answer to mimic a slow part
`timescale 1ns/100ps
module eeprom_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [2:0] i_index,
  input wire logic [27:0] i_wdata,
  output logic o_done,
  output logic [27:0] o_rdata
);
  logic [27:0] mem [8];
  logic [2:0] idx = 3'h0;
  logic wr = 1'b0;
  int wait_n = 0;
  initial begin
    o_done = 1'b0;
    o_rdata = 28'h0;
  end
  // ****
  // one word per request
  // ****
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    // read data is only valid with done; elsewhere it toggles so nothing stale passes
    o_rdata <= ~o_rdata;
    if (i_req) begin
      idx <= i_index;
      wr <= i_write;
      wait_n <= i_slow ? 6 : 1;
    end else if (wait_n == 1) begin
      o_done <= 1'b1;
      wait_n <= 0;
      if (wr) begin
        mem[idx] <= i_wdata;
      end else begin
        o_rdata <= mem[idx];
      end
    end else if (wait_n > 1) begin
      wait_n <= wait_n - 1;
    end
  end
endmodule : eeprom_model

// ---- test/param_save_monitor.sv ----
// param_save_monitor: concurrent checks on the ports of the register bank
// assumes one clock and the synchronous active-high reset
`timescale 1ns/100ps
`include "param_save_cfg.svh"
module param_save_monitor (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_frame_clk,
  input wire logic i_save_trigger,
  input wire logic i_trigger_falling,
  input wire logic i_self_boot,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire param_save_pkg::reg_addr_t i_reg_addr,
  input wire param_save_pkg::reg_word_t i_reg_wdata,
  input wire param_save_pkg::reg_word_t o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic [`PIN_COUNT-1:0] o_pin_out,
  input wire logic o_aux_data_host_write_mode,
  input wire logic o_store_req,
  input wire logic o_store_write,
  input wire logic [2:0] o_store_index,
  input wire logic i_store_done,
  input wire logic o_store_busy
);
  import param_save_pkg::*;
  logic [7:0] frame_hist;
  logic recent_rise;
  // frame clock history: pins may only move a few cycles after a frame edge
  always_ff @(posedge i_clk) begin
    frame_hist <= {frame_hist[6:0], i_frame_clk};
  end
  assign recent_rise = |(frame_hist[6:0] & ~frame_hist[7:1]);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ****
  // properties
  // ****
  property p_rd_answer; i_reg_rd |=> o_reg_rvalid; endproperty
  property p_rvalid_cause; o_reg_rvalid |-> $past(i_reg_rd); endproperty
  property p_save_pad;
    o_reg_rvalid && $past(i_reg_addr) >= 16'h0800 && $past(i_reg_addr) <= 16'h0807
      |-> o_reg_rdata[31:28] == 4'h0;
  endproperty
  property p_pin_pad;
    o_reg_rvalid && $past(i_reg_addr) == 16'h0808 |-> o_reg_rdata[31:12] == 20'h0;
  endproperty
  property p_ctl_read;
    o_reg_rvalid && $past(i_reg_addr) == 16'h081c
      |-> o_reg_rdata[31:16] == 16'h0 && o_reg_rdata[8] == o_aux_data_host_write_mode;
  endproperty
  property p_aux_bit;
    i_reg_wr && i_reg_addr == 16'h081c |=> o_aux_data_host_write_mode == $past(i_reg_wdata[8]);
  endproperty
  property p_pin_frame; $changed(o_pin_out) |-> recent_rise; endproperty
  property p_trig;
    (($rose(i_save_trigger) && !i_trigger_falling) || ($fell(i_save_trigger) && i_trigger_falling))
      && !o_store_busy |-> ##[1:6] (o_store_req && o_store_write && o_store_index == 3'h0);
  endproperty
  property p_next_word;
    i_store_done && o_store_index != 3'h7
      |=> o_store_req && o_store_index == $past(o_store_index) + 3'h1;
  endproperty
  property p_last_word; i_store_done && o_store_index == 3'h7 |=> !o_store_busy; endproperty
  property p_req_pulse; o_store_req |-> o_store_busy ##1 !o_store_req; endproperty
  property p_boot;
    $fell(i_sys_rst) && i_self_boot |-> ##[1:2] (o_store_req && !o_store_write);
  endproperty
  // ****
  // assertions
  // ****
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray read valid");
  a_save_pad: assert property (p_save_pad) else $error("save word pad not zero");
  a_pin_pad: assert property (p_pin_pad) else $error("pin level pad not zero");
  a_ctl_read: assert property (p_ctl_read) else $error("control read mismatch");
  a_aux_bit: assert property (p_aux_bit) else $error("aux mode bit wrong");
  a_pin_frame: assert property (p_pin_frame) else $error("pins moved off frame");
  a_trig: assert property (p_trig) else $error("trigger did not start save");
  a_next_word: assert property (p_next_word) else $error("next word not requested");
  a_last_word: assert property (p_last_word) else $error("busy after last word");
  a_req_pulse: assert property (p_req_pulse) else $error("store request not a pulse");
  a_boot: assert property (p_boot) else $error("no restore after boot");
  c_save: cover property (i_store_done && o_store_write && o_store_index == 3'h7);
  c_restore: cover property (i_store_done && !o_store_write && o_store_index == 3'h7);
  c_pins: cover property ($changed(o_pin_out));
endmodule : param_save_monitor

bind param_save_regs param_save_monitor param_save_monitor_i (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_frame_clk(i_frame_clk),
  .i_save_trigger(i_save_trigger), .i_trigger_falling(i_trigger_falling),
  .i_self_boot(i_self_boot), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .o_pin_out(o_pin_out),
  .o_aux_data_host_write_mode(o_aux_data_host_write_mode), .o_store_req(o_store_req),
  .o_store_write(o_store_write), .o_store_index(o_store_index),
  .i_store_done(i_store_done), .o_store_busy(o_store_busy));

// ---- test/tb.sv ----
// tb: self-checking bench for the parameter-save and pin-level register bank
// assumes param_save_pkg is compiled first and param_save_cfg.svh is on the include path
`timescale 1ns/100ps
`include "param_save_cfg.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb;
  import param_save_pkg::*;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_frame_clk = 1'b0, i_save_trigger = 1'b0;
  logic i_trigger_falling = 1'b0, i_self_boot = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  reg_addr_t i_reg_addr = 16'h0;
  reg_word_t i_reg_wdata = 32'h0, o_reg_rdata;
  logic [223:0] i_core_params = '0;
  logic [11:0] i_core_pin_level = 12'h0, i_pin_in = 12'h0, o_pin_out;
  logic [47:0] o_pin_config;
  logic [27:0] o_store_wdata, i_store_rdata;
  logic [2:0] o_store_index;
  logic o_reg_rvalid, o_aux_data_host_write_mode, o_store_req, o_store_write, i_store_done;
  logic o_store_busy, slow = 1'b0;
  int miscompares = 0, n_compared = 0;
  always #5 i_clk = ~i_clk;
  param_save_regs param_save_regs_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_frame_clk(i_frame_clk), .i_save_trigger(i_save_trigger),
    .i_trigger_falling(i_trigger_falling), .i_self_boot(i_self_boot), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_core_params(i_core_params),
    .i_core_pin_level(i_core_pin_level), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
    .o_pin_config(o_pin_config), .o_aux_data_host_write_mode(o_aux_data_host_write_mode),
    .o_store_req(o_store_req), .o_store_write(o_store_write), .o_store_index(o_store_index),
    .o_store_wdata(o_store_wdata), .i_store_rdata(i_store_rdata),
    .i_store_done(i_store_done), .o_store_busy(o_store_busy));
  eeprom_model eeprom_model_i (.i_clk(i_clk), .i_slow(slow), .i_req(o_store_req),
    .i_write(o_store_write), .i_index(o_store_index), .i_wdata(o_store_wdata),
    .o_done(i_store_done), .o_rdata(i_store_rdata));
  // ****
  // shared tasks
  // ****
  task automatic test_done();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  task automatic reg_wr(input reg_addr_t a, input reg_word_t d);
    @(posedge i_clk);
    #1;
    {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
    @(posedge i_clk);
    #1;
    i_reg_wr = 1'b0;
  endtask : reg_wr
  task automatic rd_chk(input reg_addr_t a, input reg_word_t ex, input string nm);
    @(posedge i_clk);
    #1;
    {i_reg_rd, i_reg_addr} = {1'b1, a};
    @(posedge i_clk);
    #1;
    i_reg_rd = 1'b0;
    `CHK("read valid", 1'b1, o_reg_rvalid)
    `CHK(nm, ex, o_reg_rdata)
  endtask : rd_chk
  // one frame clock period; the tick lands a few cycles after the rise
  task automatic frame();
    @(posedge i_clk);
    #1;
    i_frame_clk = 1'b1;
    repeat (5) @(posedge i_clk);
    #1;
    i_frame_clk = 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
  endtask : frame
  task automatic wait_busy(input logic lvl);
    int n;
    for (n = 0; n < 300 && o_store_busy !== lvl; n++) begin
      @(posedge i_clk);
      #1;
    end
    if (n == 300) begin
      miscompares++;
      $display("ERROR store busy expected %b seen %b", lvl, o_store_busy);
      test_done();
    end
  endtask : wait_busy
  task automatic save_and_check(input logic [3:0] tag_hi);
    wait_busy(1'b1);
    wait_busy(1'b0);
    for (int k = 0; k < 8; k++) `CHK("saved word", {4'(k), tag_hi, 20'h3c3c3}, eeprom_model_i.mem[k])
  endtask : save_and_check
  // ****
  // scenarios
  // ****
  task automatic t_reset_vals();
    reg_addr_t al[9] = '{16'h0800, 16'h0807, 16'h0808, 16'h081c, 16'h081d, 16'h0820,
      16'h0821, 16'h0823, 16'h0830};
    foreach (al[k]) rd_chk(al[k], 32'h0, "reset value");
  endtask : t_reset_vals
  task automatic t_core_refresh();
    for (int k = 0; k < 8; k++) i_core_params[k*28+:28] = {4'(k), 24'hf5a5a5};
    frame();
    for (int k = 0; k < 8; k++) rd_chk(16'h0800 + 16'(k), {8'(k), 24'hf5a5a5}, "core word");
    reg_wr(16'h0803, 32'h0123_4567);
    rd_chk(16'h0803, 32'h03f5_a5a5, "ignored host write");
  endtask : t_core_refresh
  task automatic t_host_save();
    reg_wr(16'h081c, 32'h0000_0140);
    `CHK("aux mode", 1'b1, o_aux_data_host_write_mode)
    rd_chk(16'h081c, 32'h0000_0140, "core control");
    for (int k = 0; k < 8; k++) reg_wr(16'h0800 + 16'(k), {4'hf, 4'(k), 24'h93c3c3});
    i_core_params = ~i_core_params;
    frame();
    for (int k = 0; k < 8; k++) rd_chk(16'h0800 + 16'(k), {8'(k), 24'h93c3c3}, "host word");
    i_save_trigger = 1'b1;
    save_and_check(4'h9);
    for (int k = 0; k < 8; k++) reg_wr(16'h0800 + 16'(k), {8'(k), 24'h53c3c3});
    slow = 1'b1;
    i_trigger_falling = 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    i_save_trigger = 1'b0;
    save_and_check(4'h5);
  endtask : t_host_save
  task automatic t_restore();
    i_self_boot = 1'b1;
    i_sys_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    i_self_boot = 1'b0;
    rd_chk(16'h081c, 32'h0, "control after reset");
    for (int k = 0; k < 8; k++) rd_chk(16'h0800 + 16'(k), {8'(k), 24'h53c3c3}, "restored");
  endtask : t_restore
  task automatic t_pins();
    i_core_pin_level = 12'ha5c;
    i_pin_in = 12'h3e1;
    repeat (8) @(posedge i_clk);
    #1;
    `CHK("pins before frame", 12'h000, o_pin_out)
    frame();
    `CHK("core pins", 12'ha5c, o_pin_out)
    reg_wr(16'h0808, 32'h0000_0777);
    rd_chk(16'h0808, 32'h0000_03e1, "pin inputs");
    reg_wr(16'h081c, 32'h0000_0080);
    reg_wr(16'h0808, 32'hffff_f0f0);
    repeat (8) @(posedge i_clk);
    #1;
    `CHK("pins held", 12'ha5c, o_pin_out)
    frame();
    `CHK("host pins", 12'h0f0, o_pin_out)
    rd_chk(16'h0808, 32'h0000_00f0, "host levels");
  endtask : t_pins
  task automatic t_config();
    reg_wr(16'h0820, 32'hff12_3456);
    reg_wr(16'h0821, 32'h00ab_cdef);
    `CHK("pin config", 48'habcdef_123456, o_pin_config)
    rd_chk(16'h0820, 32'h0012_3456, "config low");
    rd_chk(16'h0821, 32'h00ab_cdef, "config high");
  endtask : t_config
  initial begin
    repeat (20) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    t_reset_vals();
    t_core_refresh();
    t_host_save();
    t_restore();
    t_pins();
    t_config();
    test_done();
  end
endmodule : tb
